// ---- core/gp2_cfg.svh ----
// Address indices, field masks and reset values of the port-2 event block.
// Assumes word-wide AHB-Lite access: byte address is four times the index.
`ifndef GP2_CFG_SVH
`define GP2_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define GP2_IDX_DIRECTION    8'hD0
`define GP2_IDX_OUTPUT_VALUE 8'hD1
`define GP2_IDX_PIN_LEVEL    8'hD2
`define GP2_IDX_DRIVE_TYPE   8'hD3
`define GP2_IDX_WAKE_ENABLE  8'hD4
`define GP2_IDX_EDGE_SELECT  8'hD5
`define GP2_IDX_EVENT_STATUS 8'hD6
`define GP2_IDX_IRQ_STATUS   8'hF8
`define GP2_IDX_IRQ_MASK     8'hF9

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define GP2_IDX_LSB          2
`define GP2_IDX_MSB          9
`define GP2_EVENT_PINS       8'h3C
`define GP2_OD_ONLY_PINS     8'h08
`define GP2_BYTE_RESET       8'h00
`define GP2_WORD_ZERO        32'h0000_0000

`endif

// ---- core/gp2_pkg.sv ----
// Types shared by the port-2 event block and its edge detector.
// Assumes gp2_cfg.svh is on the include path.
`include "gp2_cfg.svh"

package gp2_pkg;

  typedef logic [7:0]  gp2_byte_t;
  typedef logic [31:0] gp2_word_t;

  typedef struct packed {
    gp2_byte_t direction;
    gp2_byte_t output_value;
    gp2_byte_t pin_level;
    gp2_byte_t drive_type;
    gp2_byte_t wake_enable;
    gp2_byte_t edge_select;
    gp2_byte_t event_status;
    gp2_byte_t irq_status;
    gp2_byte_t irq_mask;
    gp2_byte_t pin_out;
    gp2_byte_t pin_oe;
    gp2_word_t rdata;
    logic      ready;
    logic      wake_n;
    logic      irq;
    logic      wr_pend;
    gp2_byte_t wr_idx;
  } gp2_state_t;

  typedef struct packed {
    gp2_byte_t prev_level;
  } gp2_edge_state_t;

endpackage : gp2_pkg

// ---- core/gp2_edge_det.sv ----
// Per-pin edge detector for the port-2 event pins.
// Assumes the level input is already a registered sample in the CLK domain.
`timescale 1ns/10ps
`default_nettype none

module gp2_edge_det
#(
  parameter int NPINS = 8
)
(
  input  wire logic             CLK,      // System clock
  input  wire logic             NRST,     // Synchronous reset, active low
  input  wire logic [NPINS-1:0] level,    // Sampled pin levels
  input  wire logic [NPINS-1:0] fall_sel, // 1 falling, 0 rising
  input  wire logic [NPINS-1:0] armed,    // Pin may record events
  output logic      [NPINS-1:0] pulse     // One-cycle edge seen
);
  import gp2_pkg::*;

  initial
  begin
    if (NPINS != $bits(gp2_byte_t))
      $error("gp2_edge_det: NPINS must match the byte type");
  end

  gp2_edge_state_t s;
  gp2_edge_state_t n;

  always_comb
  begin
    n = s;
    n.prev_level = level;
  end

  always_ff @(posedge CLK)
  begin
    // The level keeps being tracked in reset, so release never shows a false edge
    if (!NRST)
      s.prev_level <= level;
    else
      s <= n;
  end

  // ----------------------------------------------------------------------------
  // Edge selection
  // ----------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NPINS; i++)
    begin : g_pin
      // Disarmed pins still track the level, so turning to input raises no false edge
      assign pulse[i] = armed[i] & (fall_sel[i] ? (s.prev_level[i] & ~level[i])
                                                : (~s.prev_level[i] & level[i]));
    end
  endgenerate

endmodule : gp2_edge_det

`default_nettype wire

// ---- core/gp2_event_port.sv ----
// Function
// - Output-value bits set driven pin level
// - Pin-level register reads sampled pin levels
// - Drive-type bit: 0 open-drain, 1 push-pull
// - Pin 3 never drives actively high
// - Status and wake-enable both set raise wake
// - Edge-select bit: 0 rising, 1 falling
// - Detected edge sets event-status bit
// - Event bit stays until written one
// - Events recorded only in input mode
// - Direction bit: 0 input, 1 output
//
// Port-2 general-purpose pins with edge events, wake output and interrupt.
// Assumes a single AHB-Lite master with word transfers and pins synchronous to CLK.
`timescale 1ns/10ps
`default_nettype none
`include "gp2_cfg.svh"

module gp2_event_port
#(
  parameter int NPINS  = 8,
  parameter int ADDR_W = 12
)
(
  input  wire logic              CLK,                // System clock, 50 MHz
  input  wire logic              NRST,               // Synchronous reset, active low
  input  wire logic              HSEL,               // Slave select
  input  wire logic [ADDR_W-1:0] HADDR,              // Byte address
  input  wire logic [1:0]        HTRANS,             // Transfer type
  input  wire logic              HWRITE,             // Write when high
  input  wire logic [2:0]        HSIZE,              // Transfer size, word only
  input  wire gp2_pkg::gp2_word_t HWDATA,            // Write data
  input  wire logic              HREADY,             // Bus ready in
  output gp2_pkg::gp2_word_t     HRDATA,             // Read data
  output logic                   HREADYOUT,          // Slave ready
  output logic                   HRESP,              // Always OKAY
  input  wire logic [NPINS-1:0]  PIN_IN,             // Pin levels
  output logic      [NPINS-1:0]  PIN_OUT,            // Pin drive value
  output logic      [NPINS-1:0]  PIN_OE,             // Pin driven when high
  output logic                   POWER_WAKE_EVENT_N, // Wake event, active low
  output logic                   IRQ                 // Interrupt level
);
  import gp2_pkg::*;

  // ----------------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------------
  initial
  begin
    if (NPINS != $bits(gp2_byte_t))
      $error("gp2_event_port: NPINS must be 8");
    if (ADDR_W <= `GP2_IDX_MSB + 1)
      $error("gp2_event_port: ADDR_W too small for the register map");
  end

  gp2_state_t s;
  gp2_state_t n;

  logic [NPINS-1:0] evt_pulse;
  logic [NPINS-1:0] push_pull;
  logic             accept;
  logic             mapped;
  gp2_byte_t        idx;
  gp2_byte_t        rd_byte;
  gp2_byte_t        wbyte;

  // ----------------------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------------------
  gp2_edge_det #(
    .NPINS (NPINS)
  ) u_edge (
    .CLK      (CLK),
    .NRST     (NRST),
    .level    (s.pin_level),
    .fall_sel (s.edge_select),
    .armed    (~s.direction & `GP2_EVENT_PINS),
    .pulse    (evt_pulse)
  );

  // ----------------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------------
  assign idx    = HADDR[`GP2_IDX_MSB:`GP2_IDX_LSB];
  assign accept = HSEL & HTRANS[1] & HREADY;
  assign wbyte  = HWDATA[7:0];

  always_comb
  begin
    mapped = (HADDR[ADDR_W-1:`GP2_IDX_MSB+1] == '0);
    case (idx)
      `GP2_IDX_DIRECTION,
      `GP2_IDX_OUTPUT_VALUE,
      `GP2_IDX_PIN_LEVEL,
      `GP2_IDX_DRIVE_TYPE,
      `GP2_IDX_WAKE_ENABLE,
      `GP2_IDX_EDGE_SELECT,
      `GP2_IDX_EVENT_STATUS,
      `GP2_IDX_IRQ_STATUS,
      `GP2_IDX_IRQ_MASK: mapped = mapped;
      default:           mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    n           = s;
    rd_byte     = `GP2_BYTE_RESET;
    n.pin_level = PIN_IN;

    // Data phase of a write lands here
    if (s.wr_pend)
    begin
      case (s.wr_idx)
        `GP2_IDX_DIRECTION:    n.direction    = wbyte;
        `GP2_IDX_OUTPUT_VALUE: n.output_value = wbyte;
        // Pin 3 has no push-pull stage, so its bit is held at zero
        `GP2_IDX_DRIVE_TYPE:   n.drive_type   = wbyte & ~`GP2_OD_ONLY_PINS;
        `GP2_IDX_WAKE_ENABLE:  n.wake_enable  = wbyte & `GP2_EVENT_PINS;
        `GP2_IDX_EDGE_SELECT:  n.edge_select  = wbyte & `GP2_EVENT_PINS;
        `GP2_IDX_EVENT_STATUS: n.event_status = s.event_status & ~wbyte;
        `GP2_IDX_IRQ_MASK:     n.irq_mask     = wbyte & `GP2_EVENT_PINS;
        default:               n.direction    = n.direction;
      endcase
    end

    // A new edge overrides a clear in the same cycle
    n.event_status = n.event_status | (evt_pulse & `GP2_EVENT_PINS);
    n.irq_status   = n.irq_status | (evt_pulse & `GP2_EVENT_PINS);

    // Address phase
    n.wr_pend = accept & HWRITE & mapped;
    n.wr_idx  = idx;
    n.rdata   = `GP2_WORD_ZERO;
    if (accept && !HWRITE && mapped)
    begin
      // Read sees the write landing this cycle, so back-to-back write/read is coherent
      case (idx)
        `GP2_IDX_DIRECTION:    rd_byte = n.direction;
        `GP2_IDX_OUTPUT_VALUE: rd_byte = n.output_value;
        `GP2_IDX_PIN_LEVEL:    rd_byte = s.pin_level;
        `GP2_IDX_DRIVE_TYPE:   rd_byte = n.drive_type;
        `GP2_IDX_WAKE_ENABLE:  rd_byte = n.wake_enable;
        `GP2_IDX_EDGE_SELECT:  rd_byte = n.edge_select;
        `GP2_IDX_EVENT_STATUS: rd_byte = n.event_status;
        `GP2_IDX_IRQ_STATUS:   rd_byte = n.irq_status;
        `GP2_IDX_IRQ_MASK:     rd_byte = n.irq_mask;
        default:               rd_byte = `GP2_BYTE_RESET;
      endcase
      n.rdata = {24'h00_0000, rd_byte};
      // Events arriving now are already in the returned value, so nothing is lost
      if (idx == `GP2_IDX_IRQ_STATUS)
        n.irq_status = `GP2_BYTE_RESET;
    end
    n.ready = 1'b1;

    // Pin drive: open drain only ever pulls low
    push_pull = n.drive_type & ~`GP2_OD_ONLY_PINS;
    n.pin_out = n.output_value;
    n.pin_oe  = n.direction & (~n.output_value | push_pull);

    n.wake_n = ~|(n.event_status & n.wake_enable & `GP2_EVENT_PINS);
    n.irq    = |(n.irq_status & n.irq_mask);
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      s        <= '0;
      s.ready  <= 1'b1;
      s.wake_n <= 1'b1;
      // A pin that is already high at release must not look like a rising edge
      s.pin_level <= PIN_IN;
    end
    else
      s <= n;
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign HRDATA             = s.rdata;
  assign HREADYOUT          = s.ready;
  assign HRESP              = 1'b0;
  assign PIN_OUT            = s.pin_out;
  assign PIN_OE             = s.pin_oe;
  assign POWER_WAKE_EVENT_N = s.wake_n;
  assign IRQ                = s.irq;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  a_out_value_drive: assert property (
    @(posedge CLK) disable iff (!NRST)
    (s.wr_pend && s.wr_idx == `GP2_IDX_OUTPUT_VALUE) |=> (PIN_OUT == $past(wbyte)))
  else $error("pin output value does not follow written value");

  a_level_read: assert property (
    @(posedge CLK) disable iff (!NRST)
    (accept && !HWRITE && mapped && idx == `GP2_IDX_PIN_LEVEL) |=> (HRDATA[7:0] == $past(PIN_IN, 2)))
  else $error("pin level read returns wrong value");

  a_push_pull_high: assert property (
    @(posedge CLK) disable iff (!NRST)
    (n.direction[7] && n.output_value[7] && n.drive_type[7]) |=> (PIN_OE[7] && PIN_OUT[7]))
  else $error("push-pull pin not driven high");

  a_pin3_no_high: assert property (
    @(posedge CLK) disable iff (!NRST)
    PIN_OE[3] |-> !PIN_OUT[3])
  else $error("pin 3 drives high");

  a_wake_assert: assert property (
    @(posedge CLK) disable iff (!NRST)
    ((s.event_status & s.wake_enable & `GP2_EVENT_PINS) != '0)
      && !(s.wr_pend && s.wr_idx inside {`GP2_IDX_EVENT_STATUS, `GP2_IDX_WAKE_ENABLE})
      |=> !POWER_WAKE_EVENT_N)
  else $error("wake event missing");

  a_rising_detect: assert property (
    @(posedge CLK) disable iff (!NRST)
    (!s.direction[2] && !s.edge_select[2] && $rose(s.pin_level[2])) |-> evt_pulse[2])
  else $error("rising edge on pin 2 not detected");

  a_event_latch: assert property (
    @(posedge CLK) disable iff (!NRST)
    (evt_pulse != '0) |=> ((s.event_status & $past(evt_pulse)) == $past(evt_pulse)))
  else $error("detected edge not latched");

  a_event_sticky: assert property (
    @(posedge CLK) disable iff (!NRST)
    (s.event_status[2] && !(s.wr_pend && s.wr_idx == `GP2_IDX_EVENT_STATUS && wbyte[2]))
      |=> s.event_status[2])
  else $error("event bit cleared without a written one");

  a_output_no_event: assert property (
    @(posedge CLK) disable iff (!NRST)
    s.direction[4] |-> !evt_pulse[4])
  else $error("event recorded on output pin");

  a_direction_write: assert property (
    @(posedge CLK) disable iff (!NRST)
    (s.wr_pend && s.wr_idx == `GP2_IDX_DIRECTION) |=> (s.direction == $past(wbyte)))
  else $error("direction write lost");

  // ----------------------------------------------------------------------------
  // Assertions: drive, level sampling and register writes
  // ----------------------------------------------------------------------------
  a_open_drain_release: assert property (
    @(posedge CLK) disable iff (!NRST)
    (n.direction[0] && n.output_value[0] && !n.drive_type[0]) |=> !PIN_OE[0])
  else $error("open-drain pin driven while output is one");

  a_drive_low: assert property (
    @(posedge CLK) disable iff (!NRST)
    (n.direction[1] && !n.output_value[1]) |=> (PIN_OE[1] && !PIN_OUT[1]))
  else $error("output pin not pulled low");

  a_push_pull_drives: assert property (
    @(posedge CLK) disable iff (!NRST)
    (n.direction[6] && n.drive_type[6]) |=> PIN_OE[6])
  else $error("push-pull output pin not driven");

  a_input_released: assert property (
    @(posedge CLK) disable iff (!NRST)
    (PIN_OE & ~s.direction) == '0)
  else $error("input pin is driven");

  a_out_follows_reg: assert property (
    @(posedge CLK) disable iff (!NRST)
    PIN_OUT == s.output_value)
  else $error("pin output differs from output value register");

  a_level_sample: assert property (
    @(posedge CLK) disable iff (!NRST)
    1'b1 |=> (s.pin_level == $past(PIN_IN)))
  else $error("pin level sample is stale");

  a_pin3_stored_zero: assert property (
    @(posedge CLK) disable iff (!NRST)
    (s.drive_type & `GP2_OD_ONLY_PINS) == '0)
  else $error("pin 3 push-pull bit set");

  a_drive_type_write: assert property (
    @(posedge CLK) disable iff (!NRST)
    (s.wr_pend && s.wr_idx == `GP2_IDX_DRIVE_TYPE) |=> (s.drive_type == ($past(wbyte) & ~`GP2_OD_ONLY_PINS)))
  else $error("drive type write lost");

  // ----------------------------------------------------------------------------
  // Assertions: events and wake
  // ----------------------------------------------------------------------------
  a_wake_release: assert property (
    @(posedge CLK) disable iff (!NRST)
    ((n.event_status & n.wake_enable & `GP2_EVENT_PINS) == '0) |=> POWER_WAKE_EVENT_N)
  else $error("wake event without an enabled status bit");

  a_wake_enable_write: assert property (
    @(posedge CLK) disable iff (!NRST)
    (s.wr_pend && s.wr_idx == `GP2_IDX_WAKE_ENABLE) |=> (s.wake_enable == ($past(wbyte) & `GP2_EVENT_PINS)))
  else $error("wake enable write lost");

  a_falling_detect: assert property (
    @(posedge CLK) disable iff (!NRST)
    (!s.direction[3] && s.edge_select[3] && $fell(s.pin_level[3])) |-> evt_pulse[3])
  else $error("falling edge on pin 3 not detected");

  a_wrong_edge_quiet: assert property (
    @(posedge CLK) disable iff (!NRST)
    (s.edge_select[4] && $rose(s.pin_level[4])) |-> !evt_pulse[4])
  else $error("rising edge on pin 4 reported with falling select");

  a_edge_select_write: assert property (
    @(posedge CLK) disable iff (!NRST)
    (s.wr_pend && s.wr_idx == `GP2_IDX_EDGE_SELECT) |=> (s.edge_select == ($past(wbyte) & `GP2_EVENT_PINS)))
  else $error("edge select write lost");

  a_event_pins_only: assert property (
    @(posedge CLK) disable iff (!NRST)
    (s.event_status & ~`GP2_EVENT_PINS) == '0)
  else $error("event status set outside pins 5 to 2");

  a_status_read: assert property (
    @(posedge CLK) disable iff (!NRST)
    (accept && !HWRITE && mapped && idx == `GP2_IDX_EVENT_STATUS && !s.wr_pend)
      |=> (HRDATA[7:0] == ($past(s.event_status) | $past(evt_pulse))))
  else $error("event status read returns wrong value");

  a_event_clear: assert property (
    @(posedge CLK) disable iff (!NRST)
    (s.wr_pend && s.wr_idx == `GP2_IDX_EVENT_STATUS && wbyte[5] && !evt_pulse[5])
      |=> !s.event_status[5])
  else $error("written one did not clear event bit");

  a_clear_write_exact: assert property (
    @(posedge CLK) disable iff (!NRST)
    (s.wr_pend && s.wr_idx == `GP2_IDX_EVENT_STATUS)
      |=> (s.event_status == (($past(s.event_status) & ~$past(wbyte)) | $past(evt_pulse))))
  else $error("zero write changed an event bit or a clear beat a new edge");

  a_outputs_quiet: assert property (
    @(posedge CLK) disable iff (!NRST)
    (evt_pulse & s.direction) == '0)
  else $error("edge reported on a pin in output mode");

endmodule : gp2_event_port

`default_nettype wire

// ---- test/gp2_board.sv ----
// Board model for the port-2 pins.
// Assumes the testbench sets the board-side source level at clock edges.
`timescale 1ns/10ps
`default_nettype none

module gp2_board
(
  input  wire logic [7:0] pin_out, // Port drive value
  input  wire logic [7:0] pin_oe,  // Port drives when high
  input  wire logic [7:0] ext_lvl, // Board source level
  output logic      [7:0] pin_lvl  // Resolved pin level
);
  // Released pins show the board source, never the port's last value
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : gp2_board

`default_nettype wire

// ---- test/tb_gpio_port2_event_logic.sv ----
// Self-checking testbench of the port-2 event block.
// Assumes the design package, config header and board model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "gp2_cfg.svh"

module tb_gpio_port2_event_logic;
  import gp2_pkg::*;
  logic        CLK, NRST, HSEL, HWRITE, HREADYOUT, HRESP, POWER_WAKE_EVENT_N, IRQ;
  logic [11:0] HADDR;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  gp2_word_t   HWDATA, HRDATA, rv;
  gp2_byte_t   PIN_IN, PIN_OUT, PIN_OE, ext_lvl, dir, val, drv, oe, m;
  int          fail_count, n_tests;

  gp2_event_port gp2_event_port_i (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .POWER_WAKE_EVENT_N(POWER_WAKE_EVENT_N), .IRQ(IRQ));
  gp2_board gp2_board_i (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext_lvl(ext_lvl), .pin_lvl(PIN_IN));

  // ----------------------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------------------
  function automatic gp2_byte_t exp_oe(gp2_byte_t d, gp2_byte_t v, gp2_byte_t t);
    return d & (~v | (t & 8'hF7));
  endfunction : exp_oe

  task automatic chk(input gp2_word_t seen, input gp2_word_t exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Master waits on hready; read data is taken at the edge ending the data phase
  task automatic bus(input logic w, input gp2_byte_t idx, input gp2_word_t wd, output gp2_word_t rd);
    @(posedge CLK);
    HSEL   <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR  <= {2'b00, idx, 2'b00};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    #1;
  endtask : bus

  task automatic wr(input gp2_byte_t idx, input gp2_byte_t d);
    bus(1'b1, idx, {24'h00_0000, d}, rv);
  endtask : wr

  task automatic rd_chk(input gp2_byte_t idx, input gp2_byte_t exp);
    bus(1'b0, idx, `GP2_WORD_ZERO, rv);
    chk(rv, {24'h00_0000, exp});
  endtask : rd_chk

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  // Whole run is a few hundred cycles; this cuts a hung handshake
  initial
  begin
    #400000;
    fail_count++;
    close_out();
  end

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  initial
  begin
    {NRST, HSEL, HWRITE, HADDR, HTRANS, HWDATA, ext_lvl} = '0;
    HSIZE      = 3'b010;
    fail_count = 0;
    n_tests    = 0;
    rv         = $urandom(5);
    repeat (6) @(posedge CLK);
    NRST <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      if (i != 2)
      begin
        rd_chk({4'hD, 1'b0, 3'(i)}, 8'h00);
      end
    end
    rd_chk(`GP2_IDX_IRQ_MASK, 8'h00);
    chk(PIN_OE, 8'h00);
    chk({IRQ, POWER_WAKE_EVENT_N}, 2'b01);
    chk({HREADYOUT, HRESP}, 2'b10);
    wr(8'h10, 8'hAB);
    rd_chk(8'h10, 8'h00);
    $display("reset and map test done");

    // Random drive settings; first pass writes all ones, asking for pin 3 push-pull high
    for (int i = 0; i < 10; i++)
    begin
      dir = (i == 0) ? 8'hFF : 8'($urandom);
      val = (i == 0) ? 8'hFF : 8'($urandom);
      drv = (i == 0) ? 8'hFF : 8'($urandom);
      @(posedge CLK);
      ext_lvl <= 8'($urandom);
      wr(`GP2_IDX_DIRECTION, dir);
      wr(`GP2_IDX_OUTPUT_VALUE, val);
      wr(`GP2_IDX_DRIVE_TYPE, drv);
      oe = exp_oe(dir, val, drv);
      chk(PIN_OE, oe);
      chk(PIN_OUT, val);
      rd_chk(`GP2_IDX_DIRECTION, dir);
      rd_chk(`GP2_IDX_DRIVE_TYPE, drv & 8'hF7);
      rd_chk(`GP2_IDX_PIN_LEVEL, (oe & val) | (~oe & ext_lvl));
    end
    $display("drive test done");

    // Every event pin, both edges; interrupt masked on the falling pass
    wr(`GP2_IDX_DIRECTION, 8'h00);
    wr(`GP2_IDX_WAKE_ENABLE, 8'hFF);
    for (int s = 0; s < 2; s++)
    begin
      wr(`GP2_IDX_IRQ_MASK, s[0] ? 8'h00 : 8'hFF);
      for (int p = 2; p < 6; p++)
      begin
        m = 8'h01 << p;
        wr(`GP2_IDX_EDGE_SELECT, s[0] ? 8'hFF : 8'h00);
        rd_chk(`GP2_IDX_EDGE_SELECT, s[0] ? 8'h3C : 8'h00);
        @(posedge CLK);
        ext_lvl <= s[0] ? 8'hFF : 8'h00;
        wr(`GP2_IDX_EVENT_STATUS, 8'hFF);
        bus(1'b0, `GP2_IDX_IRQ_STATUS, `GP2_WORD_ZERO, rv);
        @(posedge CLK);
        ext_lvl <= ext_lvl ^ m ^ 8'hC3;
        tick(3);
        chk(IRQ, !s[0]);
        chk(POWER_WAKE_EVENT_N, 1'b0);
        rd_chk(`GP2_IDX_EVENT_STATUS, m);
        wr(`GP2_IDX_EVENT_STATUS, ~m);
        rd_chk(`GP2_IDX_EVENT_STATUS, m);
        rd_chk(`GP2_IDX_IRQ_STATUS, m);
        wr(`GP2_IDX_EVENT_STATUS, m);
        tick(1);
        chk({IRQ, POWER_WAKE_EVENT_N}, 2'b01);
        rd_chk(`GP2_IDX_EVENT_STATUS, 8'h00);
      end
    end
    $display("event test done");

    // Edges seen while the pins are outputs must not latch
    wr(`GP2_IDX_EDGE_SELECT, 8'h00);
    @(posedge CLK);
    ext_lvl <= 8'h00;
    wr(`GP2_IDX_OUTPUT_VALUE, 8'h00);
    wr(`GP2_IDX_EVENT_STATUS, 8'hFF);
    wr(`GP2_IDX_DRIVE_TYPE, 8'h3C);
    wr(`GP2_IDX_DIRECTION, 8'h3C);
    wr(`GP2_IDX_OUTPUT_VALUE, 8'h3C);
    @(posedge CLK);
    ext_lvl <= 8'h3C;
    tick(3);
    rd_chk(`GP2_IDX_EVENT_STATUS, 8'h00);
    rd_chk(`GP2_IDX_PIN_LEVEL, 8'h3C);
    chk(POWER_WAKE_EVENT_N, 1'b1);
    $display("output mode test done");
    close_out();
  end
endmodule : tb_gpio_port2_event_logic

`default_nettype wire
